/* verilog/cma_defs.svh */
// Offsets, field positions, reset values and cycle counts of the chained datapath.
`ifndef CMA_DEFS_SVH
`define CMA_DEFS_SVH
`define CMA_ADDR_W        2
`define CMA_OFS_CTRL      2'h0
`define CMA_OFS_STATUS    2'h1
`define CMA_OFS_SUM       2'h2
`define CMA_OFS_PROD      2'h3
`define CMA_CTRL_RESET    4'h2
`define CMA_PIPE_LSB      0
`define CMA_PIPE_MSB      2
`define CMA_EDGE_BIT      3
`define CMA_ST_ILLEGAL    0
`define CMA_ST_REFUSED    1
`define CMA_SUM_HOLD      2'h2
`define CMA_POS_STEP      2'h3
`define CMA_SOP_STEP      2'h2
`endif

/* verilog/cma_pkg.sv */
// Types shared by the chained multiplier and ALU datapath.
package cma_pkg;
    typedef enum logic [2:0] {
        CMA_OP_ADD,
        CMA_OP_SUB,
        CMA_OP_MUL,
        CMA_OP_CONV,
        CMA_OP_ABS,
        CMA_OP_WRAP
    } cma_op_t;
    typedef enum logic [1:0] {
        CMA_SRC_IN,
        CMA_SRC_P,
        CMA_SRC_S,
        CMA_SRC_C
    } cma_src_t;
    typedef struct packed {
        cma_src_t mul_a;
        cma_src_t mul_b;
        cma_src_t alu_a;
        cma_src_t alu_b;
    } cma_sel_t;
    typedef struct packed {
        logic     valid;
        logic     chained;
        logic     dp;
        logic     acc_zero;
        logic     copy_c;
        cma_op_t  op;
        cma_sel_t operand_source_select;
    } cma_instr_t;
endpackage

/* verilog/cma_chained_alu.sv */
// Chained multiplier and ALU datapath with product, sum and feedback registers.
`timescale 1ns/100ps
`include "cma_defs.svh"
// How it works
// - Chained mode runs multiplier and ALU together in one instruction.
// - No conversion, absolute value or denormal wrap while chained.
// - Multiplier may take input registers while ALU takes product and sum.
// - Single precision sum of four products ends in cycle 6.
// - First double chained step holds S off, dropping the stale sum.
// - Sum and latest product feed the multiplier for the next step.
// - Product of sums step takes three clocks, sum of products two.
module cma_chained_alu #(
    parameter int DATA_W = 32
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire cma_pkg::cma_instr_t    instr_i,
    input  wire logic [DATA_W-1:0]      da_i,
    input  wire logic [DATA_W-1:0]      db_i,
    input  wire logic                   first_input_hold_enable_i,
    input  wire logic                   second_input_hold_enable_i,
    input  wire logic [`CMA_ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [31:0]            reg_rdata_o,
    output logic      [DATA_W-1:0]      product_o,
    output logic      [DATA_W-1:0]      sum_o,
    output logic                        busy_o
);
    // ***************************************************************
    // Operand selection
    // ***************************************************************
    logic [DATA_W-1:0] first_input_holding_reg;
    logic [DATA_W-1:0] second_input_holding_reg;
    logic [DATA_W-1:0] prod;
    logic [DATA_W-1:0] sum;
    logic [DATA_W-1:0] fb_hold;
    logic [DATA_W-1:0] mul_pipe;
    logic              mul_pipe_vld;
    logic [3:0]        ctrl;
    logic [1:0]        status;
    logic [1:0]        sum_hold;
    logic [1:0]        step_cnt;
    logic              in_chain;

    function automatic logic [DATA_W-1:0] pick(
        input cma_pkg::cma_src_t src,
        input logic [DATA_W-1:0] in_val
    );
        case (src)
            cma_pkg::CMA_SRC_IN: pick = in_val;
            cma_pkg::CMA_SRC_P:  pick = prod;
            cma_pkg::CMA_SRC_S:  pick = sum;
            cma_pkg::CMA_SRC_C:  pick = fb_hold;
            default:             pick = '0;
        endcase
    endfunction

    cma_pkg::cma_sel_t sel;
    logic [DATA_W-1:0] mul_a;
    logic [DATA_W-1:0] mul_b;
    logic [DATA_W-1:0] alu_a;
    logic [DATA_W-1:0] alu_b;
    logic [DATA_W-1:0] alu_res;
    logic              illegal;
    logic              refused;
    logic              go;
    logic              do_mul;
    logic              do_alu;

    always_comb
    begin
        sel   = instr_i.operand_source_select;
        mul_a = pick(sel.mul_a, first_input_holding_reg);
        mul_b = pick(sel.mul_b, second_input_holding_reg);
        alu_a = instr_i.acc_zero ? '0
              : pick(sel.alu_a, first_input_holding_reg);
        alu_b = pick(sel.alu_b, second_input_holding_reg);
        // Only add, subtract and multiply exist while chained.
        illegal = instr_i.valid && instr_i.chained
               && (instr_i.op != cma_pkg::CMA_OP_ADD)
               && (instr_i.op != cma_pkg::CMA_OP_SUB)
               && (instr_i.op != cma_pkg::CMA_OP_MUL);
        refused = instr_i.valid && instr_i.chained && busy_o;
        go      = instr_i.valid && !illegal && !refused;
        do_mul  = go && (instr_i.chained
                  || instr_i.op == cma_pkg::CMA_OP_MUL);
        do_alu  = go && (instr_i.chained
                  || instr_i.op != cma_pkg::CMA_OP_MUL);
        alu_res = (instr_i.op == cma_pkg::CMA_OP_SUB && !instr_i.chained)
                ? DATA_W'(alu_a - alu_b) : DATA_W'(alu_a + alu_b);
    end

    // ***************************************************************
    // Datapath registers
    // ***************************************************************
    logic [DATA_W-1:0] next_first_hold;
    logic [DATA_W-1:0] next_second_hold;
    logic [DATA_W-1:0] next_prod;
    logic [DATA_W-1:0] next_sum;
    logic [DATA_W-1:0] next_fb;
    logic [DATA_W-1:0] next_mul_pipe;
    logic              next_mul_vld;
    logic [1:0]        next_sum_hold;
    logic [1:0]        next_step;
    logic              next_in_chain;
    logic              dp_start;

    always_comb
    begin
        next_first_hold  = first_input_hold_enable_i ? da_i
                         : first_input_holding_reg;
        next_second_hold = second_input_hold_enable_i ? db_i
                         : second_input_holding_reg;
        next_prod     = prod;
        next_sum      = sum;
        next_fb       = (go && instr_i.copy_c) ? prod : fb_hold;
        next_mul_pipe = mul_pipe;
        next_mul_vld  = 1'b0;
        next_in_chain = go ? instr_i.chained : in_chain;
        next_sum_hold = (sum_hold != 2'h0) ? 2'(sum_hold - 2'h1) : 2'h0;
        next_step     = (step_cnt != 2'h0) ? 2'(step_cnt - 2'h1) : 2'h0;
        dp_start      = go && instr_i.chained && instr_i.dp && !in_chain;
        // A double product needs one extra stage before it reaches P.
        if (mul_pipe_vld)
        begin
            next_prod = mul_pipe;
        end
        if (do_mul && instr_i.dp)
        begin
            next_mul_pipe = DATA_W'(mul_a * mul_b);
            next_mul_vld  = 1'b1;
        end
        else if (do_mul)
        begin
            next_prod = DATA_W'(mul_a * mul_b);
        end
        // The first double chained sum is stale; S waits for the good one.
        if (dp_start)
        begin
            next_sum_hold = `CMA_SUM_HOLD;
        end
        else if (do_alu && sum_hold == 2'h0)
        begin
            next_sum = alu_res;
        end
        // Feeding S and P back into the multiplier costs a third clock.
        if (go && instr_i.chained && instr_i.dp)
        begin
            next_step = (sel.mul_a == cma_pkg::CMA_SRC_S)
                      ? 2'(`CMA_POS_STEP - 2'h1)
                      : 2'(`CMA_SOP_STEP - 2'h1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            first_input_holding_reg  <= '0;
            second_input_holding_reg <= '0;
            prod                     <= '0;
            sum                      <= '0;
            fb_hold                  <= '0;
            mul_pipe                 <= '0;
            mul_pipe_vld             <= 1'b0;
            sum_hold                 <= 2'h0;
            step_cnt                 <= 2'h0;
            in_chain                 <= 1'b0;
        end
        else
        begin
            first_input_holding_reg  <= next_first_hold;
            second_input_holding_reg <= next_second_hold;
            prod                     <= next_prod;
            sum                      <= next_sum;
            fb_hold                  <= next_fb;
            mul_pipe                 <= next_mul_pipe;
            mul_pipe_vld             <= next_mul_vld;
            sum_hold                 <= next_sum_hold;
            step_cnt                 <= next_step;
            in_chain                 <= next_in_chain;
        end
    end

    assign busy_o    = (step_cnt != 2'h0);
    assign product_o = prod;
    assign sum_o     = sum;

    // ***************************************************************
    // Register port
    // ***************************************************************
    logic [3:0]  next_ctrl;
    logic [1:0]  next_status;
    logic [31:0] next_rdata;

    always_comb
    begin
        next_ctrl   = ctrl;
        next_status = status;
        next_rdata  = 32'h0;
        if (reg_wr_i && reg_addr_i == `CMA_OFS_CTRL)
        begin
            next_ctrl = reg_wdata_i[3:0];
        end
        if (reg_wr_i && reg_addr_i == `CMA_OFS_STATUS)
        begin
            next_status = status & ~reg_wdata_i[1:0];
        end
        // An event in the clearing cycle is kept.
        if (illegal)
        begin
            next_status[`CMA_ST_ILLEGAL] = 1'b1;
        end
        if (refused)
        begin
            next_status[`CMA_ST_REFUSED] = 1'b1;
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `CMA_OFS_CTRL:   next_rdata = {28'h0, ctrl};
                `CMA_OFS_STATUS: next_rdata = {30'h0, status};
                `CMA_OFS_SUM:    next_rdata = 32'(sum);
                `CMA_OFS_PROD:   next_rdata = 32'(prod);
                default:         next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl        <= `CMA_CTRL_RESET;
            status      <= 2'h0;
            reg_rdata_o <= 32'h0;
        end
        else
        begin
            ctrl        <= next_ctrl;
            status      <= next_status;
            reg_rdata_o <= next_rdata;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence sp_mul_issued;
        do_mul && !instr_i.dp;
    endsequence

    chk_chain_both_run: assert property (
        go && instr_i.chained |-> do_mul && do_alu)
        else $error("chained instruction did not run both units");
    chk_chain_illegal_op: assert property (
        illegal |=> status[0] && $stable(sum)
        && ($past(mul_pipe_vld) || $stable(prod)))
        else $error("illegal chained op was not refused");
    chk_sp_product: assert property (
        sp_mul_issued |=> prod == DATA_W'($past(mul_a) * $past(mul_b)))
        else $error("product register missed its operands");
    chk_sum_update: assert property (
        do_alu && !dp_start && sum_hold == 2'h0
        |=> sum == $past(alu_res))
        else $error("sum register missed the alu result");
    chk_sum_hold_off: assert property (
        dp_start |=> $stable(sum) [*2])
        else $error("sum loaded before the held off edge");
    chk_dp_product: assert property (
        do_mul && instr_i.dp
        |=> ##1 prod == DATA_W'($past(mul_a, 2) * $past(mul_b, 2)))
        else $error("double product did not reach P two clocks on");
    chk_pos_step: assert property (
        go && instr_i.chained && instr_i.dp
        && sel.mul_a == cma_pkg::CMA_SRC_S |=> busy_o [*2] ##1 !busy_o)
        else $error("product of sums step is not three clocks");
    chk_refuse_busy: assert property (
        busy_o && instr_i.valid && instr_i.chained |=> status[1])
        else $error("busy chained request was not flagged");
    chk_read_data: assert property (
        reg_rd_i && reg_addr_i == `CMA_OFS_SUM
        |=> reg_rdata_o == 32'($past(sum)))
        else $error("sum read returned wrong data");
endmodule

/* tb/cma_ctrl_model.sv */
// Controller model that drives instructions and operands into the datapath.
`timescale 1ns/100ps
module cma_ctrl_model (
    input  wire logic           clk_sys_i,
    output cma_pkg::cma_instr_t instr_o,
    output logic [31:0]         da_o,
    output logic [31:0]         db_o,
    output logic                en_o
);
    localparam cma_pkg::cma_src_t S_IN = cma_pkg::CMA_SRC_IN;
    localparam cma_pkg::cma_src_t S_P = cma_pkg::CMA_SRC_P;
    localparam cma_pkg::cma_src_t S_S = cma_pkg::CMA_SRC_S;
    localparam cma_pkg::cma_op_t O_ADD = cma_pkg::CMA_OP_ADD;

    initial
    begin
        instr_o = '0;
        da_o    = '0;
        db_o    = '0;
        en_o    = 1'b0;
    end

    // Precision is one flag for the whole instruction, so it cannot mix.
    function automatic cma_pkg::cma_instr_t chain(
        input cma_pkg::cma_op_t op, input cma_pkg::cma_src_t ma, mb, aa, ab,
        input logic ch, dp, az, cc);
        return '{1'b1, ch, dp, az, cc, op, '{ma, mb, aa, ab}};
    endfunction

    // Operand lines show the inverse of their last value when not loading.
    task send(input cma_pkg::cma_instr_t ins, input logic [31:0] a, b,
              input logic en);
        @(posedge clk_sys_i);
        instr_o <= ins;
        da_o    <= en ? a : ~da_o;
        db_o    <= en ? b : ~db_o;
        en_o    <= en;
    endtask

    task sop4(input logic [31:0] v [8]);
        send('0, v[0], v[1], 1'b1);
        send(chain(cma_pkg::CMA_OP_MUL, S_IN, S_IN, S_IN, S_IN, 0, 0, 0, 0),
             v[2], v[3], 1'b1);
        send(chain(O_ADD, S_IN, S_IN, S_IN, S_P, 1, 0, 1, 0), v[4], v[5], 1'b1);
        send(chain(O_ADD, S_IN, S_IN, S_S, S_P, 1, 0, 0, 0), v[6], v[7], 1'b1);
        send(chain(O_ADD, S_IN, S_IN, S_S, S_P, 1, 0, 0, 0), 0, 0, 1'b0);
        send(chain(O_ADD, S_IN, S_IN, S_S, S_P, 0, 0, 0, 0), 0, 0, 1'b0);
        send('0, 0, 0, 1'b0);
    endtask

    task dp_first(input logic [31:0] a, b);
        send('0, a, b, 1'b1);
        send(chain(O_ADD, S_IN, S_IN, S_S, S_P, 1, 1, 0, 1), 0, 0, 1'b0);
    endtask

    task pos_step(input logic [31:0] a, b);
        send(chain(O_ADD, S_S, S_P, S_IN, S_IN, 1, 1, 0, 0), a, b, 1'b1);
        send(chain(O_ADD, S_IN, S_IN, S_IN, S_IN, 0, 0, 0, 0), 0, 0, 1'b0);
        send('0, 0, 0, 1'b0);
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking testbench for the chained multiplier and ALU datapath.
`timescale 1ns/100ps
`include "cma_defs.svh"
module tb_top;
    logic                clk_sys_i;
    logic                rst_i;
    cma_pkg::cma_instr_t instr;
    logic [31:0]         da, db, rdata, prod, sum, d, ms, mp, xa, xb, wdata;
    logic                en, wr, rd, busy;
    logic [1:0]          addr;
    logic [31:0]         v [8];
    int                  errors;
    int                  checks_done;

    cma_ctrl_model ctl (.clk_sys_i(clk_sys_i), .instr_o(instr), .da_o(da),
                        .db_o(db), .en_o(en));
    cma_chained_alu dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr),
        .da_i(da), .db_i(db), .first_input_hold_enable_i(en),
        .second_input_hold_enable_i(en), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .product_o(prod), .sum_o(sum), .busy_o(busy));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************
    // Bus tasks, comparison and closing report
    // ****************************************
    task reg_write(input logic [1:0] a, input logic [31:0] w);
        @(posedge clk_sys_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= w;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
    endtask

    task reg_read(input logic [1:0] a, output logic [31:0] r);
        @(posedge clk_sys_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd   <= 1'b0;
        #1 r = rdata;
    endtask

    task check(input string name, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        summarize;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_i = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        errors = 0;
        checks_done = 0;
        void'($urandom(21331));
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        reg_read(`CMA_OFS_CTRL, d);
        check("ctrl reset", {28'h0, `CMA_CTRL_RESET}, d);
        reg_read(`CMA_OFS_STATUS, d);
        check("status reset", 32'h0, d);
        reg_write(`CMA_OFS_CTRL, 32'hff);
        reg_read(`CMA_OFS_CTRL, d);
        check("ctrl write", 32'hf, d);
        reg_write(`CMA_OFS_CTRL, 32'h2);
        ms = '0;
        for (int i = 0; i < 8; i++) v[i] = $urandom & 32'hffff;
        for (int i = 0; i < 8; i += 2) ms += v[i] * v[i+1];
        ctl.sop4(v);
        #1 check("sum of four", ms, sum);
        for (int i = 3; i < 6; i++)
        begin
            ctl.send(ctl.chain(cma_pkg::cma_op_t'(i), ctl.S_IN, ctl.S_IN,
                     ctl.S_S, ctl.S_P, 1, 0, 0, 0), 0, 0, 1'b0);
            ctl.send('0, 0, 0, 1'b0);
            #1 check("refused op sum", ms, sum);
        end
        reg_read(`CMA_OFS_STATUS, d);
        check("illegal flag", 32'h1, d);
        reg_write(`CMA_OFS_STATUS, 32'h1);
        reg_read(`CMA_OFS_STATUS, d);
        check("status clear", 32'h0, d);
        reg_write(`CMA_OFS_CTRL, 32'h0);
        reg_read(`CMA_OFS_CTRL, d);
        check("ctrl all stages", 32'h0, d);
        xa = $urandom & 32'hffff;
        xb = $urandom & 32'hffff;
        mp = xa * xb;
        ctl.dp_first(xa, xb);
        ctl.send(ctl.chain(ctl.O_ADD, ctl.S_IN, ctl.S_IN, ctl.S_S, ctl.S_P,
                 1, 1, 0, 0), 0, 0, 1'b0);
        // A plain add inside the hold window must not reach the sum.
        ctl.send(ctl.chain(ctl.O_ADD, ctl.S_IN, ctl.S_IN, ctl.S_S, ctl.S_P,
                 0, 0, 0, 0), 0, 0, 1'b0);
        ctl.send('0, 0, 0, 1'b0);
        #1 check("held sum", ms, sum);
        check("dp product", mp, prod);
        reg_read(`CMA_OFS_STATUS, d);
        check("busy refusal", 32'h2, d);
        fork
            ctl.pos_step(xa, xb);
            begin
                repeat (2) @(posedge clk_sys_i);
                #1 check("busy first", 32'h1, {31'h0, busy});
                @(posedge clk_sys_i);
                #1 check("busy second", 32'h1, {31'h0, busy});
                check("fed back product", ms * mp, prod);
                @(posedge clk_sys_i);
                #1 check("busy done", 32'h0, {31'h0, busy});
            end
        join
        reg_read(`CMA_OFS_SUM, d);
        check("sum reg", ms, d);
        reg_read(`CMA_OFS_PROD, d);
        check("product reg", ms * mp, d);
        ctl.send(ctl.chain(cma_pkg::CMA_OP_SUB, ctl.S_IN, ctl.S_IN,
                 cma_pkg::CMA_SRC_C, ctl.S_IN, 0, 0, 0, 0), 0, 0, 1'b0);
        ctl.send('0, 0, 0, 1'b0);
        #1 check("feedback copy", v[6] * v[7] - xb, sum);
        summarize;
    end
endmodule
